/* File: rtl/cbit_cfg.svh */
// constant values for the configuration base, identity and test register slice
`ifndef CBIT_CFG_SVH
`define CBIT_CFG_SVH

// ----------------------------------------------------------------
// register indices inside the configuration space
// ----------------------------------------------------------------
`define CBIT_IDX_DEVICE_IDENTITY 8'h0d
`define CBIT_IDX_SILICON_REVISION 8'h0e
`define CBIT_IDX_TEST_CONTROL_ONE 8'h0f
`define CBIT_IDX_TEST_CONTROL_TWO 8'h10
`define CBIT_IDX_TEST_CONTROL_THREE 8'h11
`define CBIT_IDX_PORT_BASE_LOW 8'h12
`define CBIT_IDX_PORT_BASE_HIGH 8'h13
`define CBIT_IDX_RATE_SELECT_MIRROR 8'h14

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CBIT_RST_TEST_CONTROL_ONE 8'h00
`define CBIT_RST_TEST_CONTROL_TWO 8'h00
`define CBIT_RST_TEST_CONTROL_THREE 8'h80
`define CBIT_RST_BASE_LOW_STRAP0 8'h2e
`define CBIT_RST_BASE_LOW_STRAP1 8'h4e
`define CBIT_RST_BASE_HIGH 8'h00
`define CBIT_RST_RATE_SELECT 8'h80
`define CBIT_RST_INDEX 8'h00
`define CBIT_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define CBIT_BASE_LOW_MASK 8'hfe
`define CBIT_BASE_HIGH_MASK 8'h07
`define CBIT_RATE_MIRROR_MASK 8'hdf
`define CBIT_RATE_LSB 0
`define CBIT_PRECOMP_LSB 2
`define CBIT_LOW_POWER_BIT 6
`define CBIT_SOFT_RESET_BIT 7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CBIT_CLK_PERIOD_NS 100
`define CBIT_SOFT_RESET_NS 100
`define CBIT_SOFT_RESET_CYCLES (((`CBIT_SOFT_RESET_NS) + (`CBIT_CLK_PERIOD_NS) - 1) / (`CBIT_CLK_PERIOD_NS))
`define CBIT_STRAP_SETTLE_CYCLES 2

`endif

/* File: rtl/cbit_config_regs.sv */
// configuration base address, identity and test register slice
//
// Overview of operation
// R01: identity at index 0dh, config state, read-only
// R02: identity returns fixed eight-bit part code
// R03: revision at index 0eh, read-only, starts zero; the code returns REVISION_CODE, default 03
// R04: software leaves test registers strictly alone
// R05: test registers writable, reset 00, 00, 80
// R06: low base holds address 7..1, bit0 zero
// R07: high base holds address 10..8, rest zero
// R08: decoder needs address bits 15..11 zero
// R09: port base always even, address bit0 zero
// R10: base resets 2e or 4e by strap, high 00
// R11: software writes low byte then high byte
// R12: decoder moves only on high byte write
// R13: index 14h mirrors write-only rate register
// R14: mirror bits: rate, precomp, bit5 zero
// R15: bit6 one enters manual low power
// R16: bit7 zero resets controller, self clears
// R17: read-only and reserved bits ignore writes
`timescale 1ns/1ns
`default_nettype none
`include "cbit_cfg.svh"

module cbit_config_regs
	import cbit_pkg::*;
#(
	parameter logic [7:0] DEVICE_CODE = 8'ha7, // arbitrary value
	parameter logic [7:0] REVISION_CODE = 8'h03 // arbitrary value
) (
	// clock and power-on reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// board pins
	input wire logic hardResetPin,
	input wire logic base_select_strap,
	// configuration state from the entry sequencer
	input wire logic configState,
	// host i/o cycles from the lpc front end
	input wire logic [15:0] ioAddr,
	input wire logic [7:0] ioWrData,
	input wire logic ioWrStrobe,
	input wire logic ioRdStrobe,
	output logic [7:0] ioRdData,
	output logic ioRdValid,
	output logic ioClaim,
	// run-time rate register writes from the floppy front end
	input wire logic rateWrStrobe,
	input wire logic [7:0] rateWrData,
	// floppy controller controls
	output logic [1:0] floppyDataRate,
	output logic [2:0] write_precomp_select,
	output logic manual_low_power_bit,
	output logic controller_soft_reset_bit,
	// active decoder base
	output logic [15:0] configPortBase
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	cbit_decode_if decIf (); // decoder link

	logic hardSync1; // hard reset pin, first stage
	logic hardSync2; // hard reset pin, settled
	logic strapSync1; // strap pin, first stage
	logic strapSync2; // strap pin, settled

	cbit_strap_state_t strapState; // strap capture sequencer
	cbit_strap_state_t next_strapState;
	logic [1:0] settleCount; // cycles waited for the strap to settle

	cbit_byte_t config_index_register; // selects the data port target
	cbit_byte_t test_control_one;
	cbit_byte_t test_control_two;
	cbit_byte_t test_control_three;
	cbit_byte_t port_base_low_byte;
	cbit_byte_t port_base_high_byte;
	cbit_base_t activeBase; // what the decoder uses right now
	cbit_byte_t rateSelect; // copy of the write-only rate register
	logic [1:0] softResetCount; // remaining controller reset cycles

	logic indexWrite; // host writes the index port
	logic dataWrite; // host writes the data port in config state
	logic anyRead; // host reads one of the two ports

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// true when a data port write hits the given index
	function automatic logic hitsReg(input cbit_byte_t idx, input cbit_byte_t code);
		hitsReg = (idx == code);
	endfunction

	// reset value of the low base byte for a given strap level
	function automatic cbit_byte_t strapBase(input logic strap);
		strapBase = strap ? `CBIT_RST_BASE_LOW_STRAP1 : `CBIT_RST_BASE_LOW_STRAP0;
	endfunction

	// decoder base from the two base bytes
	function automatic cbit_base_t joinBase(input cbit_byte_t high, input cbit_byte_t low);
		joinBase = {high[2:0], low[7:1]};
	endfunction

	// ----------------------------------------------------------------
	// decoder
	// ----------------------------------------------------------------
	assign decIf.ioAddr = ioAddr;
	assign decIf.baseBits = activeBase;
	assign decIf.baseValid = (strapState == STRAP_READY);

	cbit_port_decoder portDecoder (
		.dec(decIf.decoder)
	);

	// neither port is taken or claimed outside configuration state
	assign indexWrite = ioWrStrobe && decIf.hitIndex && configState;
	assign dataWrite = ioWrStrobe && decIf.hitData && configState; // R01
	assign anyRead = ioRdStrobe && configState && (decIf.hitIndex || decIf.hitData);
	assign ioClaim = configState && (decIf.hitIndex || decIf.hitData);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------

	// both pins are asynchronous to clk_sys
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hardSync1 <= 1'b0;
			hardSync2 <= 1'b0;
			strapSync1 <= 1'b0;
			strapSync2 <= 1'b0;
		end else begin
			hardSync1 <= hardResetPin;
			hardSync2 <= hardSync1;
			strapSync1 <= base_select_strap;
			strapSync2 <= strapSync1;
		end
	end

	// ----------------------------------------------------------------
	// strap capture sequencer
	// ----------------------------------------------------------------

	// the strap cannot be sampled under the asynchronous reset, so the
	// base is loaded a few cycles after release and the decoder waits
	always_comb begin
		next_strapState = strapState;
		case (strapState)
			STRAP_SETTLE: begin
				if (!hardSync2 && settleCount == 2'(`CBIT_STRAP_SETTLE_CYCLES)) begin
					next_strapState = STRAP_LOAD;
				end
			end
			STRAP_LOAD: begin
				next_strapState = hardSync2 ? STRAP_SETTLE : STRAP_READY;
			end
			STRAP_READY: begin
				if (hardSync2) begin
					next_strapState = STRAP_SETTLE;
				end
			end
			default: begin
				next_strapState = STRAP_SETTLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			strapState <= STRAP_SETTLE;
		end else begin
			strapState <= next_strapState;
		end
	end

	// settle counter, restarts while hard reset is held
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			settleCount <= 2'h0;
		end else if (strapState != STRAP_SETTLE || hardSync2) begin
			settleCount <= 2'h0;
		end else if (settleCount != 2'(`CBIT_STRAP_SETTLE_CYCLES)) begin
			settleCount <= settleCount + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// index register
	// ----------------------------------------------------------------

	// loaded by any write to the index port in configuration state
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			config_index_register <= `CBIT_RST_INDEX;
		end else if (indexWrite) begin
			config_index_register <= ioWrData;
		end
	end

	// ----------------------------------------------------------------
	// test control registers
	// ----------------------------------------------------------------

	// plain storage only: no test mode is wired to anything, so a stray
	// write from software cannot upset the device
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			test_control_one <= `CBIT_RST_TEST_CONTROL_ONE; // R05
			test_control_two <= `CBIT_RST_TEST_CONTROL_TWO; // R05
			test_control_three <= `CBIT_RST_TEST_CONTROL_THREE; // R05
		end else if (dataWrite) begin
			if (hitsReg(config_index_register, `CBIT_IDX_TEST_CONTROL_ONE)) begin
				test_control_one <= ioWrData; // R05
			end
			if (hitsReg(config_index_register, `CBIT_IDX_TEST_CONTROL_TWO)) begin
				test_control_two <= ioWrData; // R05
			end
			if (hitsReg(config_index_register, `CBIT_IDX_TEST_CONTROL_THREE)) begin
				test_control_three <= ioWrData; // R05
			end
		end
	end

	// ----------------------------------------------------------------
	// base address bytes
	// ----------------------------------------------------------------

	// reserved bits are masked on the way in so they always read zero
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			port_base_low_byte <= `CBIT_RST_BASE_LOW_STRAP0;
			port_base_high_byte <= `CBIT_RST_BASE_HIGH;
		end else if (strapState == STRAP_LOAD) begin
			port_base_low_byte <= strapBase(strapSync2); // R10
			port_base_high_byte <= `CBIT_RST_BASE_HIGH; // R10
		end else if (strapState == STRAP_SETTLE) begin
			port_base_high_byte <= `CBIT_RST_BASE_HIGH; // R10
		end else if (dataWrite) begin
			if (hitsReg(config_index_register, `CBIT_IDX_PORT_BASE_LOW)) begin
				port_base_low_byte <= ioWrData & `CBIT_BASE_LOW_MASK; // R06
			end
			if (hitsReg(config_index_register, `CBIT_IDX_PORT_BASE_HIGH)) begin
				port_base_high_byte <= ioWrData & `CBIT_BASE_HIGH_MASK; // R07
			end
		end
	end

	// the decoder follows only the high byte write, so a half-written
	// relocation never moves the port under the host's feet
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			activeBase <= joinBase(`CBIT_RST_BASE_HIGH, `CBIT_RST_BASE_LOW_STRAP0);
		end else if (strapState == STRAP_LOAD) begin
			activeBase <= joinBase(`CBIT_RST_BASE_HIGH, strapBase(strapSync2)); // R10
		end else if (dataWrite && hitsReg(config_index_register, `CBIT_IDX_PORT_BASE_HIGH)
			&& strapState == STRAP_READY) begin
			activeBase <= joinBase(ioWrData, port_base_low_byte); // R12
		end
	end

	assign configPortBase = {5'h00, activeBase, 1'b0}; // R09

	// ----------------------------------------------------------------
	// run-time rate register copy
	// ----------------------------------------------------------------

	// the floppy side writes it; the configuration side only looks
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rateSelect <= `CBIT_RST_RATE_SELECT;
		end else if (rateWrStrobe) begin
			rateSelect <= rateWrData & `CBIT_RATE_MIRROR_MASK; // R14
		end else if (softResetCount == 2'h1) begin
			rateSelect[`CBIT_SOFT_RESET_BIT] <= 1'b1; // R16
		end
	end

	// controller reset time after a zero lands in bit 7
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			softResetCount <= 2'h0;
		end else if (rateWrStrobe && !rateWrData[`CBIT_SOFT_RESET_BIT]) begin
			softResetCount <= 2'(`CBIT_SOFT_RESET_CYCLES); // R16
		end else if (softResetCount != 2'h0) begin
			softResetCount <= softResetCount - 2'h1;
		end
	end

	// rate, precomp and low power taken straight from the stored bits, soft reset from the counter
	assign floppyDataRate = rateSelect[`CBIT_RATE_LSB +: 2]; // R14
	assign write_precomp_select = rateSelect[`CBIT_PRECOMP_LSB +: 3]; // R14
	assign manual_low_power_bit = rateSelect[`CBIT_LOW_POWER_BIT]; // R15
	assign controller_soft_reset_bit = (softResetCount != 2'h0); // R16

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------

	// identity, revision and mirror have no write path from the data port, so a host
	// write to them changes nothing
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ioRdData <= 8'h00;
		end else if (anyRead) begin
			if (decIf.hitIndex) begin
				ioRdData <= config_index_register;
			end else begin
				case (config_index_register)
					`CBIT_IDX_DEVICE_IDENTITY: begin
						ioRdData <= DEVICE_CODE; // R01 R02 R17
					end
					`CBIT_IDX_SILICON_REVISION: begin
						ioRdData <= REVISION_CODE; // R03 R17
					end
					`CBIT_IDX_TEST_CONTROL_ONE: begin
						ioRdData <= test_control_one;
					end
					`CBIT_IDX_TEST_CONTROL_TWO: begin
						ioRdData <= test_control_two;
					end
					`CBIT_IDX_TEST_CONTROL_THREE: begin
						ioRdData <= test_control_three;
					end
					`CBIT_IDX_PORT_BASE_LOW: begin
						ioRdData <= port_base_low_byte; // R06
					end
					`CBIT_IDX_PORT_BASE_HIGH: begin
						ioRdData <= port_base_high_byte; // R07
					end
					`CBIT_IDX_RATE_SELECT_MIRROR: begin
						ioRdData <= rateSelect & `CBIT_RATE_MIRROR_MASK; // R13 R17
					end
					default: begin
						// neighbouring indices live elsewhere
						ioRdData <= `CBIT_UNMAPPED_READ;
					end
				endcase
			end
		end
	end

	// read data is valid the cycle after the strobe
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ioRdValid <= 1'b0;
		end else begin
			ioRdValid <= anyRead;
		end
	end

endmodule // cbit_config_regs

`default_nettype wire

/* File: rtl/cbit_decode_if.sv */
// signals between the register bank and its configuration port decoder
`timescale 1ns/1ns
`default_nettype none

interface cbit_decode_if;
	import cbit_pkg::*;

	logic [15:0] ioAddr; // address of the current i/o cycle
	cbit_base_t baseBits; // active decoder base
	logic baseValid; // base is settled after reset
	logic hitIndex; // cycle targets the index port
	logic hitData; // cycle targets the data port

	modport decoder (
		input ioAddr,
		input baseBits,
		input baseValid,
		output hitIndex,
		output hitData
	);

	modport bank (
		output ioAddr,
		output baseBits,
		output baseValid,
		input hitIndex,
		input hitData
	);
endinterface

`default_nettype wire

/* File: rtl/cbit_pkg.sv */
// types shared by the configuration base, identity and test register slice
package cbit_pkg;

	// strap capture sequencer states
	typedef enum logic [1:0] {
		STRAP_SETTLE,
		STRAP_LOAD,
		STRAP_READY
	} cbit_strap_state_t;

	// one configuration register byte
	typedef logic [7:0] cbit_byte_t;

	// programmed decoder base, address bits 10 down to 1
	typedef logic [10:1] cbit_base_t;

endpackage

/* File: rtl/cbit_port_decoder.sv */
// configuration port address decoder
`timescale 1ns/1ns
`default_nettype none

module cbit_port_decoder
	import cbit_pkg::*;
(
	// link to the register bank
	cbit_decode_if.decoder dec
);

	logic upperZero; // address bits 15..11 all clear
	logic pairMatch; // bits 10..1 match the base

	// ----------------------------------------------------------------
	// address compare
	// ----------------------------------------------------------------
	always_comb begin
		upperZero = (dec.ioAddr[15:11] == 5'h00); // R08
		pairMatch = (dec.ioAddr[10:1] == dec.baseBits);
		// base is even: index port at bit0 clear, data port at bit0 set
		dec.hitIndex = dec.baseValid && upperZero && pairMatch && !dec.ioAddr[0]; // R09
		dec.hitData = dec.baseValid && upperZero && pairMatch && dec.ioAddr[0];
	end

endmodule // cbit_port_decoder

`default_nettype wire

/* File: sim/cbit_config_regs_chk.sv */
// concurrent checks on the configuration register slice ports
`timescale 1ns/1ns
`default_nettype none

module cbit_config_regs_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// host cycles
	input wire logic configState,
	input wire logic [15:0] ioAddr,
	input wire logic ioRdStrobe,
	input wire logic ioWrStrobe,
	input wire logic [7:0] ioRdData,
	input wire logic ioRdValid,
	input wire logic ioClaim,
	// rate register and floppy controls
	input wire logic rateWrStrobe,
	input wire logic [7:0] rateWrData,
	input wire logic [1:0] floppyDataRate,
	input wire logic [2:0] write_precomp_select,
	input wire logic manual_low_power_bit,
	input wire logic controller_soft_reset_bit,
	input wire logic [15:0] configPortBase
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	logic [7:0] lastRate; // rate data of the previous cycle, avoids $past on a slice

	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			lastRate <= 8'h00;
		end else begin
			lastRate <= rateWrData;
		end
	end

	// soft reset request with no second write straight after
	sequence s_reset_req;
		rateWrStrobe && !rateWrData[7] ##1 !rateWrStrobe;
	endsequence

	// controller reset lasts exactly one cycle
	sequence s_reset_pulse;
		controller_soft_reset_bit ##1 !controller_soft_reset_bit;
	endsequence

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_read_answer: assert property (ioRdStrobe && ioClaim |=> ioRdValid)
		else $error("claimed read not answered");
	a_no_stray_valid: assert property (!(ioRdStrobe && ioClaim) |=> !ioRdValid)
		else $error("read answered without a claimed cycle");
	a_claim_decode: assert property (ioClaim |-> configState && ioAddr[15:11] == 5'h00
		&& ioAddr[10:1] == configPortBase[10:1])
		else $error("port claimed off its address");
	a_base_shape: assert property (configPortBase[15:11] == 5'h00 && !configPortBase[0])
		else $error("decoder base odd or above the window");
	a_rate_copy: assert property (rateWrStrobe |=> floppyDataRate == lastRate[1:0]
		&& write_precomp_select == lastRate[4:2] && manual_low_power_bit == lastRate[6])
		else $error("floppy controls differ from written rate");
	a_rate_hold: assert property (!rateWrStrobe |=> $stable(floppyDataRate)
		&& $stable(write_precomp_select) && $stable(manual_low_power_bit))
		else $error("floppy controls moved without a write");
	a_soft_pulse: assert property (s_reset_req |-> s_reset_pulse)
		else $error("controller reset pulse wrong");
	a_rddata_hold: assert property (!ioRdValid |-> $stable(ioRdData))
		else $error("read data moved without a read");
	// the decoder base moves only after a claimed write or while the ports are not claimed
	a_base_move: assert property ($changed(configPortBase) |-> ($past(ioWrStrobe) && $past(ioClaim))
		|| !$past(ioClaim))
		else $error("decoder base moved without a port write");
endmodule // cbit_config_regs_chk

bind cbit_config_regs cbit_config_regs_chk u_cbit_config_regs_chk (.clk_sys, .reset_n, .configState,
	.ioAddr, .ioRdStrobe, .ioWrStrobe, .ioRdData, .ioRdValid, .ioClaim, .rateWrStrobe, .rateWrData,
	.floppyDataRate, .write_precomp_select, .manual_low_power_bit, .controller_soft_reset_bit,
	.configPortBase);

`default_nettype wire

/* File: sim/cbit_lpc_host.sv */
// host side model issuing i/o cycles to the configuration ports
`timescale 1ns/1ns
`default_nettype none

module cbit_lpc_host (
	// clock
	input wire logic clk_sys,
	// cycle request
	output logic [15:0] ioAddr,
	output logic [7:0] ioWrData,
	output logic ioWrStrobe,
	output logic ioRdStrobe,
	// answer
	input wire logic [7:0] ioRdData,
	input wire logic ioRdValid
);
	int slow = 0; // idle cycles before each cycle, to act as a slow host

	// idle bus at time zero
	initial begin
		ioAddr = 16'hffff;
		ioWrData = 8'hff;
		ioWrStrobe = 1'b0;
		ioRdStrobe = 1'b0;
	end

	// one write cycle; bus turned to the inverse once released so stale values never match
	task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
		repeat (slow) @(posedge clk_sys);
		@(posedge clk_sys);
		ioAddr <= a;
		ioWrData <= d;
		ioWrStrobe <= 1'b1;
		@(posedge clk_sys);
		ioWrStrobe <= 1'b0;
		ioAddr <= ~a;
		ioWrData <= ~d;
	endtask

	// one read cycle; answer taken once the strobe edge has landed
	task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		repeat (slow) @(posedge clk_sys);
		@(posedge clk_sys);
		ioAddr <= a;
		ioRdStrobe <= 1'b1;
		@(posedge clk_sys);
		ioRdStrobe <= 1'b0;
		ioAddr <= ~a;
		#1;
		v = ioRdValid;
		d = ioRdData;
	endtask
endmodule // cbit_lpc_host

`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the configuration register slice
`timescale 1ns/1ns
`default_nettype none

module testbench;
	localparam logic [7:0] DEV_ID = 8'h3c; // arbitrary identity value
	localparam logic [7:0] REV_ID = 8'h02; // arbitrary revision value

	logic clk_sys = 1'b0;
	logic reset_n, hardResetPin, base_select_strap, configState, rateWrStrobe;
	logic [7:0] rateWrData, ioWrData, ioRdData;
	logic [15:0] ioAddr, configPortBase;
	logic ioWrStrobe, ioRdStrobe, ioRdValid, ioClaim;
	logic [1:0] floppyDataRate;
	logic [2:0] write_precomp_select;
	logic manual_low_power_bit, controller_soft_reset_bit;
	int n_fail = 0;
	int check_count = 0;
	int i;
	logic [15:0] base = 16'h002e; // where the bench thinks the index port is
	logic [15:0] r;
	logic [7:0] idxTab [9] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
	logic [7:0] rstTab [9] = '{DEV_ID, REV_ID, 8'h00, 8'h00, 8'h80, 8'h2e, 8'h00, 8'h80, 8'h00};

	always #50 clk_sys = ~clk_sys;

	cbit_config_regs #(.DEVICE_CODE(DEV_ID), .REVISION_CODE(REV_ID)) u_cbit_config_regs (.clk_sys, .reset_n,
		.hardResetPin, .base_select_strap, .configState, .ioAddr, .ioWrData, .ioWrStrobe, .ioRdStrobe,
		.ioRdData, .ioRdValid, .ioClaim, .rateWrStrobe, .rateWrData, .floppyDataRate,
		.write_precomp_select, .manual_low_power_bit, .controller_soft_reset_bit, .configPortBase);

	cbit_lpc_host u_cbit_lpc_host (.clk_sys, .ioAddr, .ioWrData, .ioWrStrobe, .ioRdStrobe, .ioRdData,
		.ioRdValid);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic test_done;
		if (n_fail == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// index write then data write
	task automatic cwr(input logic [7:0] idx, input logic [7:0] dat);
		u_cbit_lpc_host.io_wr(base, idx);
		u_cbit_lpc_host.io_wr(base + 16'h0001, dat);
	endtask

	// index write then data read; answer flag in bit 8
	task automatic crd(input logic [7:0] idx, output logic [15:0] res);
		logic [7:0] rd;
		logic rv;
		u_cbit_lpc_host.io_wr(base, idx);
		u_cbit_lpc_host.io_rd(base + 16'h0001, rd, rv);
		res = {7'h00, rv, rd};
	endtask

	task automatic creg(input logic [7:0] idx, input logic [7:0] exp);
		logic [15:0] res;
		crd(idx, res);
		check(res, {8'h01, exp});
	endtask

	// rate write, then sample the controls one edge after it landed
	task automatic rate_wr(input logic [7:0] dat);
		@(posedge clk_sys);
		rateWrStrobe <= 1'b1;
		rateWrData <= dat;
		@(posedge clk_sys);
		rateWrStrobe <= 1'b0;
		rateWrData <= ~dat;
		@(posedge clk_sys);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		hardResetPin = 1'b0;
		base_select_strap = 1'b0;
		configState = 1'b0;
		rateWrStrobe = 1'b0;
		rateWrData = 8'h00;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		configState <= 1'b1;
		check(configPortBase, 16'h002e);
		for (i = 0; i < 9; i++) creg(idxTab[i], rstTab[i]);
		// test registers keep writes, read-only places ignore them
		for (i = 0; i < 5; i++) cwr(idxTab[i], 8'ha5);
		cwr(8'h14, 8'ha5);
		for (i = 0; i < 5; i++) creg(idxTab[i], (i < 2) ? rstTab[i] : 8'ha5);
		creg(8'h14, 8'h80);
		for (i = 2; i < 5; i++) cwr(idxTab[i], rstTab[i]);
		// outside configuration state nothing is taken or answered
		@(posedge clk_sys) configState <= 1'b0;
		cwr(8'h0f, 8'h77);
		crd(8'h0f, r);
		check({15'h0000, r[8]}, 16'h0000);
		@(posedge clk_sys) configState <= 1'b1;
		creg(8'h0f, 8'h00);
		// the index port itself reads back the last index written
		u_cbit_lpc_host.io_rd(base, r[7:0], r[8]);
		check(r, 16'h010f);
		// relocation through a slow host
		u_cbit_lpc_host.slow = 2;
		cwr(8'h12, 8'h7f);
		repeat (2) @(posedge clk_sys);
		check(configPortBase, 16'h002e);
		creg(8'h12, 8'h7e);
		cwr(8'h13, 8'hfd);
		repeat (2) @(posedge clk_sys);
		check(configPortBase, 16'h057e);
		base = 16'h057e;
		creg(8'h13, 8'h05);
		base = 16'h002e;
		crd(8'h0d, r);
		check({15'h0000, r[8]}, 16'h0000);
		base = 16'h857e;
		crd(8'h0d, r);
		check({15'h0000, r[8]}, 16'h0000);
		// hard reset returns the base to the strap default
		@(posedge clk_sys);
		base_select_strap <= 1'b1;
		hardResetPin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		hardResetPin <= 1'b0;
		repeat (12) @(posedge clk_sys);
		check(configPortBase, 16'h004e);
		base = 16'h004e;
		creg(8'h12, 8'h4e);
		creg(8'h13, 8'h00);
		// rate register: low power, soft reset pulse and mirror
		rate_wr(8'h42);
		check({9'h000, floppyDataRate, write_precomp_select, manual_low_power_bit,
			controller_soft_reset_bit}, 16'h0043);
		@(posedge clk_sys);
		check({15'h0000, controller_soft_reset_bit}, 16'h0000);
		creg(8'h14, 8'hc2);
		rate_wr(8'hff);
		check({9'h000, floppyDataRate, write_precomp_select, manual_low_power_bit,
			controller_soft_reset_bit}, 16'h007e);
		creg(8'h14, 8'hdf);
		test_done;
	end

	// watchdog far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (4000) @(posedge clk_sys);
		n_fail++;
		test_done;
	end
endmodule // testbench

`default_nettype wire
